// file: haptic_seq_pkg.sv
// Purpose: Shared constants and types for the haptic waveform sequencer.
// Assumes: One 250 MHz system clock.
// Notes: Tick lengths are whole multiples of the shortest tick.
package haptic_seq_pkg;

  // Clock rate and the shortest tick length.
  localparam int CLK_MHZ = 250;
  localparam int TICK_BASE_NS = 1360000;
  localparam int TICK_BASE_CYCLES = TICK_BASE_NS * CLK_MHZ / 1000;

  // Waveform store size and header layout.
  localparam int MEM_BYTES = 100;
  localparam logic [6:0] HDR_CLIP_COUNT_ADDR = 7'h00;
  localparam logic [6:0] HDR_SEQ_COUNT_ADDR = 7'h01;
  localparam logic [6:0] HDR_PTR_BASE_ADDR = 7'h02;

  // Envelope point byte fields.
  localparam int PT_SLOPE_BIT = 7;
  localparam int PT_DUR_LSB = 4;
  localparam int PT_LEVEL_LSB = 0;

  // First and second frame byte fields.
  localparam int FR_TYPE_BIT = 7;
  localparam int FR_GAIN_LSB = 5;
  localparam int FR_TB_LSB = 3;
  localparam int FR_ID_LOW_LSB = 0;
  localparam int FR_LOOP_LSB = 3;
  localparam int FR_PITCH_FLAG_BIT = 2;
  localparam int FR_PITCH_MSB_BIT = 1;
  localparam int FR_ID_HIGH_BIT = 0;

  // Built-in silence clip: one zero point of two ticks.
  localparam logic [3:0] SILENCE_DUR = 4'h2;

  // Signed level limits.
  localparam logic signed [4:0] LEVEL_NEG_CODE = -5'sd8;
  localparam logic signed [4:0] LEVEL_NEG_CLAMP = -5'sd7;

  // Pitch scaling, floor and period read-back unit (microseconds).
  localparam logic [10:0] PITCH_FLOOR_HZ = 11'h019;
  localparam logic [19:0] PERIOD_US_NUM = 20'hF4240;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [10:0] PITCH_RESET = 11'h000;

  // Tick multipliers of the shortest tick, per code, normal then fast.
  localparam logic [6:0] TB_MULT_NORMAL [4] = '{7'h04, 7'h10, 7'h20, 7'h40};
  localparam logic [6:0] TB_MULT_FAST [4] = '{7'h01, 7'h04, 7'h10, 7'h20};

  typedef enum {
    ST_IDLE, ST_COUNTS, ST_SEQ_END, ST_SEQ_BEG, ST_FRAME1, ST_FRAME2, ST_FRAME3,
    ST_CLIP_END, ST_CLIP_BEG, ST_POINT, ST_PLAY, ST_END
  } seq_state_t;

endpackage : haptic_seq_pkg

// file: tick_if.sv
// Purpose: Carries tick requests and tick pulses between sequencer and divider.
// Assumes: Both ends sit on the same clock.
// Notes: The tick pulse lasts one cycle.
`timescale 1ns/100ps
interface tick_if;
  logic run;
  logic [6:0] mult;
  logic tick;
  modport gen (input run, input mult, output tick);
  modport user (output run, output mult, input tick);
endinterface : tick_if

// file: tick_divider.sv
// Purpose: Divides the system clock down to one-cycle tick enables.
// Assumes: mult is held steady while run is high.
// Notes: A low run restarts the count so each point gets full ticks.
`timescale 1ns/100ps
module tick_divider
  import haptic_seq_pkg::*;
#(
  parameter int BASE_CYCLES = TICK_BASE_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  tick_if.gen tk // Tick request and pulse.
);

  logic [19:0] base_cnt_reg;
  logic [6:0] mult_cnt_reg;
  logic tick_reg;

  // End of a shortest tick and of a whole tick.
  wire base_done = (base_cnt_reg == 20'(BASE_CYCLES - 1));
  wire tick_done = base_done && (mult_cnt_reg >= tk.mult - 7'h01);

  // Two cascaded counters driven by the system clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_cnt_reg <= 20'h00000;
      mult_cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (!tk.run) begin
      base_cnt_reg <= 20'h00000;
      mult_cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      base_cnt_reg <= base_done ? 20'h00000 : base_cnt_reg + 20'h00001;
      mult_cnt_reg <= tick_done ? 7'h00 : (base_done ? mult_cnt_reg + 7'h01 : mult_cnt_reg);
      tick_reg <= tick_done;
    end
  end

  assign tk.tick = tick_reg;

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tk.tick |=> !tk.tick)
    else $error("Tick pulses ran back to back.");

endmodule : tick_divider

// file: haptic_waveform_sequencer.sv
// Purpose: Plays stored haptic sequences from a 100-byte waveform store as an envelope.
// Assumes: Trigger and option inputs come from logic on the same clock.
// Notes: Envelope is signed, level times eight, shifted right by the attenuation code.
`timescale 1ns/100ps
// Function
// - Point byte: bit 7 slope flag, bits 6-4 duration, bits 3-0 level.
// - Slope set ramps linearly to the new level; clear jumps and holds.
// - Point duration is code plus one ticks, one to eight.
// - Acceleration on: level is unsigned, zero silent, fifteen full.
// - Acceleration off: level is signed, minus eight read as minus seven.
// - Sequence starts from zero; later clips and loops start from last level.
// - Clip zero is built-in silence, one zero point of two ticks.
// - Stored clip count excludes clip zero; user clips start at one.
// - First frame byte with top bit set raises a memory fault.
// - First frame byte: attenuation bits 6-5, tick code 4-3, clip id 2-0.
// - Second byte: loop 6-3, pitch flag 2, pitch bit 8, clip id high.
// - Attenuation codes give 0, -6, -12 and -18 dB.
// - Tick code decoded by fast-tick option into 1.36 to 87.04 ms lengths.
// - Clip plays loop count plus one times; repeats start at first point.
// - Without second byte, one play and clip id high bit zero.
// - Pitch flag set fetches a third byte as pitch low bits.
// - Pitch is two hertz per step, clamped up to 25 Hz.
// - Commanded pitch converted to a period for read-back.
// - A commanded pitch persists until another frame commands one.
// - Playback only starts by selecting a sequence.
// - Playback ends at sequence end with the level forced to zero.
// - Store holds 100 bytes for header, clips and sequences.
// - Byte 0 clip count, byte 1 sequence count, end pointers follow.
// - End pointers mark last bytes; clips from one, sequences from zero.
module haptic_waveform_sequencer
  import haptic_seq_pkg::*;
#(
  parameter int BASE_CYCLES = TICK_BASE_CYCLES
) (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic mem_wr_en, // Store write strobe.
  input wire logic [6:0] mem_wr_addr, // Store write address.
  input wire logic [7:0] mem_wr_data, // Store write data.
  input wire logic seq_start, // Pulse to start a sequence.
  input wire logic [3:0] seq_select, // Sequence to play.
  input wire logic accel_enable, // Unsigned level interpretation.
  input wire logic fast_tick_select, // Shorter tick lengths.
  input wire logic resonance_tracking_enable, // Tracking loop enable; unused, frames still set the pitch.
  output logic signed [7:0] envelope_out, // Attenuated envelope.
  output logic playing, // Sequence in progress.
  output logic mem_fault, // One-cycle memory fault event.
  output logic pitch_update, // One-cycle pulse when a frame sets pitch.
  output logic [10:0] drive_pitch_hz, // Commanded drive pitch in hertz.
  output logic [15:0] active_period_readback // Drive period in microseconds.
);

  logic [7:0] mem [MEM_BYTES];
  seq_state_t state_reg;
  logic [7:0] clip_count_reg, seq_count_reg, seq_end_reg, frame_ptr_reg;
  logic [7:0] clip_beg_reg, clip_end_reg, pt_ptr_reg;
  logic [3:0] seq_id_reg, loop_reg, pass_reg;
  logic [1:0] gain_reg, tb_reg;
  logic [2:0] id_low_reg;
  logic id_high_reg, pitch_msb_reg, silence_reg, slope_reg;
  logic [3:0] dur_reg, step_reg;
  logic signed [4:0] lvl_start_reg, lvl_tgt_reg;
  logic signed [7:0] env_reg;
  logic playing_reg, fault_reg, pitch_upd_reg;
  logic [10:0] pitch_hz_reg;
  logic [15:0] period_reg;
  tick_if tk ();

  // Tick divider instance.
  tick_divider #(.BASE_CYCLES(BASE_CYCLES)) i_tick_divider (.clk(clk), .rst(rst), .tk(tk));

  // Store write port; the contents are data and carry no reset.
  always_ff @(posedge clk) begin
    if (mem_wr_en && mem_wr_addr < 7'(MEM_BYTES)) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  // Header positions: clip pointers at byte 2, sequence pointers after them.
  wire [7:0] seq_ptr_base = 8'(HDR_PTR_BASE_ADDR) + clip_count_reg;
  wire [7:0] data_first = seq_ptr_base + seq_count_reg;
  wire [3:0] clip_id = {id_high_reg, id_low_reg};

  // Read address selection by state.
  logic [7:0] rd_addr;
  always_comb begin
    case (state_reg)
      ST_COUNTS: rd_addr = 8'(HDR_SEQ_COUNT_ADDR);
      ST_SEQ_END: rd_addr = seq_ptr_base + 8'(seq_id_reg);
      ST_SEQ_BEG: rd_addr = seq_ptr_base + 8'(seq_id_reg) - 8'h01;
      ST_CLIP_END: rd_addr = 8'(HDR_PTR_BASE_ADDR) + 8'(clip_id) - 8'h01;
      ST_CLIP_BEG: rd_addr = 8'(HDR_PTR_BASE_ADDR) + 8'(clip_id) - 8'h02;
      ST_POINT: rd_addr = pt_ptr_reg;
      ST_FRAME1, ST_FRAME2, ST_FRAME3: rd_addr = frame_ptr_reg;
      default: rd_addr = 8'(HDR_CLIP_COUNT_ADDR);
    endcase
  end
  wire [7:0] mem_q = (rd_addr < 8'(MEM_BYTES)) ? mem[rd_addr[6:0]] : 8'h00;

  // Point decode: slope flag, duration and level.
  wire pt_slope = silence_reg ? 1'b0 : mem_q[PT_SLOPE_BIT];
  wire [3:0] pt_dur = silence_reg ? SILENCE_DUR : {1'b0, mem_q[PT_DUR_LSB +: 3]} + 4'h1;
  wire [3:0] pt_code = silence_reg ? 4'h0 : mem_q[PT_LEVEL_LSB +: 4];
  wire signed [4:0] pt_signed = $signed({pt_code[3], pt_code});
  wire signed [4:0] pt_level = accel_enable ? $signed({1'b0, pt_code}) :
    ((pt_signed == LEVEL_NEG_CODE) ? LEVEL_NEG_CLAMP : pt_signed);

  // Linear interpolation over the point's ticks.
  wire signed [5:0] lvl_delta = 6'(lvl_tgt_reg) - 6'(lvl_start_reg);
  wire signed [9:0] ramp_prod = 10'(lvl_delta) * $signed({6'h00, step_reg});
  wire signed [9:0] ramp_quot = ramp_prod / $signed({6'h00, dur_reg});
  wire signed [4:0] lvl_cur = slope_reg ? 5'(10'(lvl_start_reg) + ramp_quot) : lvl_tgt_reg;

  // Attenuation: each 6 dB step halves the envelope.
  wire signed [7:0] env_full = {lvl_cur, 3'b000};
  wire signed [7:0] env_next = playing_reg ? (env_full >>> gain_reg) : 8'sh00;

  // Pitch: two hertz per step, floor at 25 Hz, then period.
  wire [10:0] pitch_raw = {1'b0, pitch_msb_reg, mem_q, 1'b0};
  wire [10:0] pitch_next = (pitch_raw < PITCH_FLOOR_HZ) ? PITCH_FLOOR_HZ : pitch_raw;
  wire [19:0] period_quot = (pitch_hz_reg == 11'h000) ? 20'h00000 :
    PERIOD_US_NUM / {9'h000, pitch_hz_reg};

  // Tick length from code and fast-tick option.
  assign tk.run = (state_reg == ST_PLAY);
  assign tk.mult = fast_tick_select ? TB_MULT_FAST[tb_reg] : TB_MULT_NORMAL[tb_reg];

  wire point_done = (state_reg == ST_PLAY) && tk.tick && (step_reg + 4'h1 == dur_reg);
  wire clip_last = silence_reg || (pt_ptr_reg == clip_end_reg);
  wire seq_last = (frame_ptr_reg > seq_end_reg);

  // Sequencing state machine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      {clip_count_reg, seq_count_reg, seq_end_reg, frame_ptr_reg} <= 32'h00000000;
      {clip_beg_reg, clip_end_reg, pt_ptr_reg} <= 24'h000000;
      {seq_id_reg, loop_reg, pass_reg, dur_reg, step_reg} <= 20'h00000;
      {gain_reg, tb_reg, id_low_reg} <= 7'h00;
      {id_high_reg, pitch_msb_reg, silence_reg, slope_reg} <= 4'h0;
      lvl_start_reg <= 5'sh00;
      lvl_tgt_reg <= 5'sh00;
      playing_reg <= 1'b0;
      fault_reg <= 1'b0;
      pitch_upd_reg <= 1'b0;
      pitch_hz_reg <= PITCH_RESET;
    end else begin
      fault_reg <= 1'b0;
      pitch_upd_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (seq_start) begin
            seq_id_reg <= seq_select;
            clip_count_reg <= mem_q;
            lvl_start_reg <= 5'sh00;
            lvl_tgt_reg <= 5'sh00;
            slope_reg <= 1'b0;
            playing_reg <= 1'b1;
            state_reg <= ST_COUNTS;
          end
        end
        ST_COUNTS: begin
          seq_count_reg <= mem_q;
          state_reg <= ST_SEQ_END;
        end
        ST_SEQ_END: begin
          seq_end_reg <= mem_q;
          if (8'(seq_id_reg) >= seq_count_reg) begin
            fault_reg <= 1'b1;
            state_reg <= ST_END;
          end else begin
            state_reg <= ST_SEQ_BEG;
          end
        end
        ST_SEQ_BEG: begin
          // Sequence zero reads the last clip end pointer here and starts just past it, or starts at data_first when no clips are stored.
          frame_ptr_reg <= (seq_id_reg == 4'h0 && clip_count_reg == 8'h00) ?
            data_first : mem_q + 8'h01;
          state_reg <= ST_FRAME1;
        end
        ST_FRAME1: begin
          if (mem_q[FR_TYPE_BIT]) begin
            fault_reg <= 1'b1;
            state_reg <= ST_END;
          end else begin
            gain_reg <= mem_q[FR_GAIN_LSB +: 2];
            tb_reg <= mem_q[FR_TB_LSB +: 2];
            id_low_reg <= mem_q[FR_ID_LOW_LSB +: 3];
            frame_ptr_reg <= frame_ptr_reg + 8'h01;
            state_reg <= ST_FRAME2;
          end
        end
        ST_FRAME2: begin
          pass_reg <= 4'h0;
          if (!seq_last && mem_q[FR_TYPE_BIT]) begin
            loop_reg <= mem_q[FR_LOOP_LSB +: 4];
            pitch_msb_reg <= mem_q[FR_PITCH_MSB_BIT];
            id_high_reg <= mem_q[FR_ID_HIGH_BIT];
            frame_ptr_reg <= frame_ptr_reg + 8'h01;
            state_reg <= mem_q[FR_PITCH_FLAG_BIT] ? ST_FRAME3 : ST_CLIP_END;
          end else begin
            loop_reg <= 4'h0;
            id_high_reg <= 1'b0;
            state_reg <= ST_CLIP_END;
          end
        end
        ST_FRAME3: begin
          pitch_hz_reg <= pitch_next;
          pitch_upd_reg <= 1'b1;
          frame_ptr_reg <= frame_ptr_reg + 8'h01;
          state_reg <= ST_CLIP_END;
        end
        ST_CLIP_END: begin
          silence_reg <= (clip_id == 4'h0);
          clip_end_reg <= mem_q;
          if (clip_id != 4'h0 && 8'(clip_id) > clip_count_reg) begin
            fault_reg <= 1'b1;
            state_reg <= ST_END;
          end else begin
            state_reg <= (clip_id == 4'h0) ? ST_POINT : ST_CLIP_BEG;
          end
        end
        ST_CLIP_BEG: begin
          clip_beg_reg <= (clip_id == 4'h1) ? data_first : mem_q + 8'h01;
          pt_ptr_reg <= (clip_id == 4'h1) ? data_first : mem_q + 8'h01;
          state_reg <= ST_POINT;
        end
        ST_POINT: begin
          lvl_start_reg <= lvl_cur;
          lvl_tgt_reg <= pt_level;
          slope_reg <= pt_slope;
          dur_reg <= pt_dur;
          step_reg <= 4'h0;
          state_reg <= ST_PLAY;
        end
        ST_PLAY: begin
          if (point_done) begin
            step_reg <= dur_reg;
            if (!clip_last) begin
              pt_ptr_reg <= pt_ptr_reg + 8'h01;
              state_reg <= ST_POINT;
            end else if (pass_reg != loop_reg) begin
              pass_reg <= pass_reg + 4'h1;
              pt_ptr_reg <= clip_beg_reg;
              state_reg <= ST_POINT;
            end else begin
              state_reg <= seq_last ? ST_END : ST_FRAME1;
            end
          end else if (tk.tick) begin
            step_reg <= step_reg + 4'h1;
          end
        end
        ST_END: begin
          lvl_start_reg <= 5'sh00;
          lvl_tgt_reg <= 5'sh00;
          slope_reg <= 1'b0;
          playing_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Output flip-flops, including the period read-back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      env_reg <= 8'sh00;
      period_reg <= PERIOD_RESET;
    end else begin
      env_reg <= env_next;
      period_reg <= period_quot[15:0];
    end
  end

  assign envelope_out = env_reg;
  assign playing = playing_reg;
  assign mem_fault = fault_reg;
  assign pitch_update = pitch_upd_reg;
  assign drive_pitch_hz = pitch_hz_reg;
  assign active_period_readback = period_reg;

  a_bad_frame_fault: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_FRAME1 && mem_q[7]) |=> (mem_fault && state_reg == ST_END))
    else $error("Bad first frame byte gave no fault.");
  a_silence_point: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_POINT && silence_reg) |=> (dur_reg == 4'h2 && lvl_tgt_reg == 5'sh00))
    else $error("Silence clip point is wrong.");
  a_dur_decode: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_POINT && !silence_reg) |=> (dur_reg == {1'b0, $past(mem_q[6:4])} + 4'h1))
    else $error("Point duration not code plus one.");
  a_step_jump: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_PLAY && !slope_reg) |-> (lvl_cur == lvl_tgt_reg))
    else $error("Step point did not jump to its level.");
  a_ramp_start: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_PLAY && slope_reg && step_reg == 4'h0) |-> (lvl_cur == lvl_start_reg))
    else $error("Ramp did not start from the previous level.");
  a_signed_clamp: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_POINT && !accel_enable && !silence_reg && mem_q[3:0] == 4'h8)
    |=> (lvl_tgt_reg == -5'sd7))
    else $error("Code minus eight not read as minus seven.");
  a_unsigned_level: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_POINT && accel_enable && !silence_reg)
    |=> (lvl_tgt_reg == $signed({1'b0, $past(mem_q[3:0])})))
    else $error("Unsigned level decode is wrong.");
  a_pitch_floor: assert property (@(posedge clk) disable iff (rst)
    pitch_update |-> ((drive_pitch_hz >= PITCH_FLOOR_HZ && !drive_pitch_hz[0]) ||
    drive_pitch_hz == PITCH_FLOOR_HZ))
    else $error("Commanded pitch below floor.");
  a_end_silent: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_END) |=> (!playing ##1 envelope_out == 8'sh00))
    else $error("Playback did not end silent.");
  a_seq_origin: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE && seq_start) |=> (lvl_cur == 5'sh00))
    else $error("Sequence did not start from zero.");

  // Frame decode, looping, header and point end checks.
  a_frame2_default: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_FRAME2 && !mem_q[FR_TYPE_BIT]) |=> (loop_reg == 4'h0 && !id_high_reg))
    else $error("Missing second frame byte gave no default.");
  a_pitch_fetch: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_FRAME2 && !seq_last && mem_q[FR_TYPE_BIT] && mem_q[FR_PITCH_FLAG_BIT])
    |=> (state_reg == ST_FRAME3 ##1 pitch_update))
    else $error("Pitch flag did not fetch a third frame byte.");
  a_loop_restart: assert property (@(posedge clk) disable iff (rst)
    (point_done && clip_last && pass_reg != loop_reg)
    |=> (state_reg == ST_POINT && pt_ptr_reg == clip_beg_reg))
    else $error("Clip repeat did not restart at its first point.");
  a_idle_wait: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_IDLE && !seq_start) |=> (state_reg == ST_IDLE && !playing))
    else $error("Playback began without a sequence start.");
  a_clip_start: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_CLIP_BEG && clip_id != 4'h1) |=> (pt_ptr_reg == $past(mem_q) + 8'h01))
    else $error("Clip did not start one past the previous end.");
  a_seq_range: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_SEQ_END && 8'(seq_id_reg) >= seq_count_reg) |=> mem_fault)
    else $error("Sequence past the stored count gave no fault.");
  a_ramp_end: assert property (@(posedge clk) disable iff (rst)
    point_done |=> (lvl_cur == lvl_tgt_reg))
    else $error("Point did not end on its own level.");

endmodule : haptic_waveform_sequencer

// file: wave_store_model.sv
// Purpose: Stands in for the host side that fills the waveform store.
// Assumes: One byte is written each cycle, launched on the falling edge.
// Notes: The image holds five clips and eight sequences.
`timescale 1ns/100ps
module wave_store_model (
  input wire logic clk, // System clock.
  input wire logic load, // Rising edge starts a load.
  output logic mem_wr_en, // Store write strobe.
  output logic [6:0] mem_wr_addr, // Store write address.
  output logic [7:0] mem_wr_data, // Store write data.
  output logic loaded // High once the image is in.
);
  localparam int IMG_LEN = 33;
  // Counts, clip end pointers, sequence end pointers, then clip and frame data.
  localparam logic [7:0] IMG [IMG_LEN] = '{
    8'h05, 8'h08, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18,
    8'h19, 8'h1C, 8'h1F, 8'h20, 8'h17, 8'h08, 8'hB4, 8'h05, 8'h0F, 8'h01, 8'h02,
    8'h03, 8'h04, 8'h90, 8'h65, 8'h00, 8'h84, 8'h0A, 8'h00, 8'h84, 8'h64, 8'h81};

  // Idle values, so nothing floats before the first load.
  initial begin
    mem_wr_en = 1'b0;
    mem_wr_addr = 7'h00;
    mem_wr_data = 8'h00;
    loaded = 1'b0;
  end

  // Streams the image, then drops the strobe and scrambles the data lines.
  always begin
    @(posedge load);
    for (int i = 0; i < IMG_LEN; i++) begin
      @(negedge clk);
      mem_wr_en <= 1'b1;
      mem_wr_addr <= 7'(i);
      mem_wr_data <= IMG[i];
    end
    @(negedge clk);
    mem_wr_en <= 1'b0;
    mem_wr_data <= ~mem_wr_data;
    loaded <= 1'b1;
  end
endmodule : wave_store_model

// file: haptic_waveform_sequencer_tb.sv
// Purpose: Plays each stored sequence and judges envelope, timing and pitch.
// Assumes: Tick base of 4 cycles; inputs change on the falling edge.
// Notes: Envelope is level times eight, shifted right by the gain code.
`timescale 1ns/100ps
module haptic_waveform_sequencer_tb;
  logic clk = 1'b0;
  logic rst, seq_start, accel_enable, fast_tick_select, resonance_tracking_enable, load;
  logic [3:0] seq_select;
  logic mem_wr_en, loaded, playing, mem_fault, pitch_update;
  logic [6:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic signed [7:0] envelope_out, env_max, env_min;
  logic [10:0] drive_pitch_hz;
  logic [15:0] active_period_readback;
  int mismatches = 0;
  int checks = 0;
  int hits, faults, updates;

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  wave_store_model i_wave_store_model (.clk(clk), .load(load), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .loaded(loaded));

  haptic_waveform_sequencer #(.BASE_CYCLES(4)) i_haptic_waveform_sequencer (.clk(clk),
    .rst(rst), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .seq_start(seq_start), .seq_select(seq_select), .accel_enable(accel_enable),
    .fast_tick_select(fast_tick_select), .envelope_out(envelope_out), .playing(playing),
    .resonance_tracking_enable(resonance_tracking_enable), .mem_fault(mem_fault),
    .pitch_update(pitch_update), .drive_pitch_hz(drive_pitch_hz),
    .active_period_readback(active_period_readback));

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Starts one sequence and gathers statistics until playback ends.
  task automatic play(input logic [3:0] id, input logic signed [7:0] watch);
    int n;
    @(negedge clk);
    seq_select = id;
    seq_start = 1'b1;
    @(negedge clk);
    seq_start = 1'b0;
    hits = 0;
    faults = 0;
    updates = 0;
    env_max = 8'sh00;
    env_min = 8'sh00;
    n = 0;
    while (playing === 1'b1 && n < 3000) begin
      if (envelope_out === watch) hits++;
      if (envelope_out > env_max) env_max = envelope_out;
      if (envelope_out < env_min) env_min = envelope_out;
      if (mem_fault === 1'b1) faults++;
      if (pitch_update === 1'b1) updates++;
      n++;
      @(negedge clk);
    end
    if (n == 3000) begin
      mismatches++;
      results();
    end
    // The last level lingers one cycle as playing falls, then the envelope drops to zero.
    if (envelope_out > env_max) env_max = envelope_out;
    if (envelope_out < env_min) env_min = envelope_out;
    @(negedge clk);
    check({8'h00, envelope_out}, 16'h0000);
  endtask : play

  // Outputs after reset.
  task automatic t_reset();
    check({15'h0000, playing}, 16'h0000);
    check({8'h00, envelope_out}, 16'h0000);
    check({5'h00, drive_pitch_hz}, 16'h0000);
    check(active_period_readback, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // Step point of two ticks, normal then fast tick table.
  // A last point shows for its ticks plus one cycle; a tick is 16 cycles normal, 4 fast.
  task automatic t_step();
    fast_tick_select = 1'b0;
    play(4'h0, 8'sd56);
    check(16'(hits), 16'h0021);
    check({8'h00, env_max}, 16'h0038);
    fast_tick_select = 1'b1;
    play(4'h0, 8'sd56);
    check(16'(hits), 16'h0009);
    $display("test step done");
  endtask : t_step

  // Level code eight read signed and unsigned, and the deepest gain.
  task automatic t_level();
    accel_enable = 1'b0;
    play(4'h1, -8'sd56);
    check(16'(hits), 16'h0005);
    check({8'h00, env_min}, 16'h00C8);
    accel_enable = 1'b1;
    play(4'h1, 8'sd64);
    check(16'(hits), 16'h0005);
    play(4'h4, 8'sd15);
    check(16'(hits), 16'h0005);
    check({8'h00, env_max}, 16'h000F);
    $display("test level done");
  endtask : t_level

  // Ramp from the zero origin to four over four ticks, then a looped clip.
  // Each repeat adds one point fetch cycle: three passes of six cycles, less one.
  task automatic t_ramp_loop();
    play(4'h2, 8'sd8);
    check(16'(hits), 16'h0004);
    check({8'h00, env_max}, 16'h0020);
    play(4'h3, 8'sd40);
    check(16'(hits), 16'h0011);
    $display("test ramp and loop done");
  endtask : t_ramp_loop

  // Silence clip with a pitch below the floor, a second pitch, then persistence.
  task automatic t_pitch();
    play(4'h5, 8'sd0);
    check({8'h00, env_max}, 16'h0000);
    check(16'(updates), 16'h0001);
    check({5'h00, drive_pitch_hz}, 16'h0019);
    check(active_period_readback, 16'h9C40);
    play(4'h6, 8'sd0);
    check({5'h00, drive_pitch_hz}, 16'h00C8);
    check(active_period_readback, 16'h1388);
    resonance_tracking_enable = 1'b1;
    play(4'h0, 8'sd56);
    resonance_tracking_enable = 1'b0;
    check(16'(updates), 16'h0000);
    check({5'h00, drive_pitch_hz}, 16'h00C8);
    $display("test pitch done");
  endtask : t_pitch

  // Bad first frame byte and a sequence number past the stored count.
  task automatic t_fault();
    play(4'h7, 8'sd0);
    check(16'(faults), 16'h0001);
    play(4'h9, 8'sd0);
    check(16'(faults), 16'h0001);
    $display("test fault done");
  endtask : t_fault

  // Reset, load the store, then run every scenario.
  initial begin
    int n;
    rst = 1'b1;
    seq_start = 1'b0;
    seq_select = 4'h0;
    accel_enable = 1'b1;
    fast_tick_select = 1'b1;
    resonance_tracking_enable = 1'b0;
    load = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset();
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    for (n = 0; n < 200 && loaded !== 1'b1; n++) @(negedge clk);
    if (loaded !== 1'b1) begin
      mismatches++;
      results();
    end
    t_step();
    t_level();
    t_ramp_loop();
    t_pitch();
    t_fault();
    results();
  end
endmodule : haptic_waveform_sequencer_tb
